// ===== cei_status_irq.sv
// Status bits, CAN error counters and two-line interrupt flag logic.
// Assumes all inputs except busRxPin are on core_clk; busRxPin is a raw pin.
`timescale 1ns/1ps
`default_nettype none
`include "cei_cfg.svh"

module cei_status_irq (
  input  wire logic                 core_clk,          // Core clock, 100 MHz.
  input  wire logic                 rst_n,             // Asynchronous reset, active low.
  input  wire logic                 busRxPin,          // Raw CAN receive pin.
  input  wire logic                 initReq,           // Initialization mode requested.
  input  wire logic                 powerDownReq,      // Power-down mode requested.
  input  wire logic                 cfgWriteReq,       // CPU configuration write attempt.
  input  wire logic                 autoBusRecoveryEn, // Automatic bus-on enable.
  input  wire logic                 globalLineSelect,  // Line for global flags.
  input  wire cei_pkg::cei_fbits_t  globalMask,        // Line enables per flag.
  input  wire logic [31:0]          mailboxMask,       // Mailbox interrupt masks.
  input  wire logic [31:0]          mailboxLevel,      // Mailbox line select.
  input  wire logic [31:0]          mailboxEvent,      // Mailbox event pulses.
  input  wire logic [31:0]          mailboxClr,        // Write-1 to tx ack / rx pending.
  input  wire logic [31:0]          timeoutStatus,     // Mailbox time-out status levels.
  input  wire logic                 abortAckAny,       // Abort acknowledge pending.
  input  wire logic                 msgLostAny,        // Receive message lost pending.
  input  wire logic                 writeDeniedEvt,    // Denied mailbox write pulse.
  input  wire logic                 wakeupEvt,         // Wake-up pulse.
  input  wire logic                 stampMsb,          // Time-stamp counter msb.
  input  wire cei_pkg::cei_sticky_t clrLine0,          // Write-1 clears, line 0.
  input  wire cei_pkg::cei_sticky_t clrLine1,          // Write-1 clears, line 1.
  input  wire cei_pkg::cei_proto_t  proto,             // Protocol engine status.
  output logic                      configWriteGrant,  // Config write access granted.
  output logic                      cfgWriteAccept,    // Config write performed.
  output logic                      powerdownAck,      // In power-down mode.
  output logic                      rxActive,          // Receiving a message.
  output logic                      txActive,          // Transmitting a message.
  output logic                      busOff,            // Bus-off state.
  output logic [8:0]                txErrorCount,      // Transmit error counter.
  output logic [7:0]                rxErrorCount,      // Receive error counter.
  output cei_pkg::cei_flags_t       flagRegLine0,      // Flag register, line 0.
  output cei_pkg::cei_flags_t       flagRegLine1,      // Flag register, line 1.
  output logic                      irqLine0,          // Interrupt line 0.
  output logic                      irqLine1           // Interrupt line 1.
);

  typedef struct packed {
    logic [1:0]              rxSync;
    logic                    rxSeenHigh;
    logic                    grant;
    logic                    cfgAccept;
    logic                    pdAck;
    logic                    rxAct;
    logic                    txAct;
    logic [8:0]              tec;
    logic [7:0]              rec;
    logic [3:0]              runLen;
    cei_pkg::cei_err_state_t errSt;
    logic                    offState;
    logic                    initPrev;
    logic                    stampPrev;
    logic [31:0]             mbPend;
    cei_pkg::cei_sticky_t    sticky0;
    cei_pkg::cei_sticky_t    sticky1;
    cei_pkg::cei_flags_t     line0;
    cei_pkg::cei_flags_t     line1;
    logic                    irq0;
    logic                    irq1;
  } cei_state_t;

  cei_state_t st;
  cei_state_t next_st;

  // Highest set index; zero when nothing is pending.
  function automatic logic [4:0] cei_highest(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 0; i < 32; i++)
    begin
      if (v[i])
        idx = 5'(i);
    end
    return idx;
  endfunction

  logic                 leaveInit;
  logic                 rxHigh;
  logic                 warnNow;
  logic                 warnNext;
  logic [31:0]          pend0;
  logic [31:0]          pend1;
  cei_pkg::cei_sticky_t stEvt;
  logic                 clrHit0;
  logic                 clrHit1;

  // Whole next state; the pin is read only after the second sync stage.
  always_comb
  begin
    next_st   = st;
    rxHigh    = st.rxSync[1];
    leaveInit = st.initPrev & ~initReq;
    next_st.rxSync    = {st.rxSync[0], busRxPin};
    next_st.initPrev  = initReq;
    next_st.stampPrev = stampMsb;

    if (st.grant)
      next_st.rxSeenHigh = 1'b0;
    else if (rxHigh)
      next_st.rxSeenHigh = 1'b1;
    next_st.grant = initReq & (st.grant | st.rxSeenHigh);
    next_st.cfgAccept = cfgWriteReq & st.grant;

    case (st.errSt)
      cei_pkg::BUS_OFF:
      begin
        if (proto.bitTick)
        begin
          if (!rxHigh)
            next_st.runLen = 4'h0;
          else if (st.runLen == `CEI_RUN_LAST)
          begin
            next_st.runLen = 4'h0;
            next_st.rec    = st.rec + 8'h01;
          end
          else
            next_st.runLen = st.runLen + 4'h1;
        end
        if (autoBusRecoveryEn && st.rec == `CEI_REC_RECOVER)
        begin
          next_st.errSt  = cei_pkg::ERR_ACTIVE;
          next_st.tec    = 9'h000;
          next_st.rec    = 8'h00;
          next_st.runLen = 4'h0;
        end
      end
      cei_pkg::ERR_ACTIVE, cei_pkg::ERR_PASSIVE:
      begin
        if (proto.txErr)
          next_st.tec = (st.tec >= `CEI_BUSOFF_LIMIT - `CEI_TX_ERR_STEP) ?
                        `CEI_BUSOFF_LIMIT : st.tec + `CEI_TX_ERR_STEP;
        else if (proto.txOk && st.tec != 9'h000)
          next_st.tec = st.tec - 9'h001;
        if (proto.rxOk)
          next_st.rec = ({1'b0, st.rec} >= `CEI_PASSIVE_LIMIT) ? `CEI_REC_RELOAD :
                        (st.rec != 8'h00) ? st.rec - 8'h01 : 8'h00;
        else if ({1'b0, st.rec} < `CEI_PASSIVE_LIMIT)
        begin
          if (proto.rxErr8)
            next_st.rec = st.rec + `CEI_RX_ERR_STEP;
          else if (proto.rxErr1)
            next_st.rec = st.rec + 8'h01;
        end
        if (next_st.tec >= `CEI_BUSOFF_LIMIT)
        begin
          next_st.errSt  = cei_pkg::BUS_OFF;
          next_st.rec    = 8'h00;
          next_st.runLen = 4'h0;
        end
        else if (next_st.tec >= `CEI_PASSIVE_LIMIT ||
                 {1'b0, next_st.rec} >= `CEI_PASSIVE_LIMIT)
          next_st.errSt = cei_pkg::ERR_PASSIVE;
        else
          next_st.errSt = cei_pkg::ERR_ACTIVE;
      end
      default:
        next_st.errSt = cei_pkg::ERR_ACTIVE;
    endcase

    if (leaveInit)
    begin
      next_st.errSt  = cei_pkg::ERR_ACTIVE;
      next_st.tec    = 9'h000;
      next_st.rec    = 8'h00;
      next_st.runLen = 4'h0;
    end

    // power-down acknowledge, entered only between frames.
    next_st.pdAck = powerDownReq & (st.pdAck | (~proto.rxBusy & ~proto.txBusy));
    next_st.rxAct = proto.rxBusy & (next_st.errSt != cei_pkg::BUS_OFF);
    next_st.txAct = proto.txBusy & (next_st.errSt != cei_pkg::BUS_OFF);
    // bus-off status kept in a flop so the pin has no decode behind it.
    next_st.offState = next_st.errSt == cei_pkg::BUS_OFF;

    // Warning is not raised by the recovery count during bus-off.
    warnNow  = st.errSt != cei_pkg::BUS_OFF &&
               (st.tec >= `CEI_WARN_LIMIT || {1'b0, st.rec} >= `CEI_WARN_LIMIT);
    warnNext = next_st.errSt != cei_pkg::BUS_OFF &&
               (next_st.tec >= `CEI_WARN_LIMIT ||
                {1'b0, next_st.rec} >= `CEI_WARN_LIMIT);

    stEvt.writeDenied = writeDeniedEvt | (cfgWriteReq & ~st.grant);
    stEvt.wakeup      = wakeupEvt;
    stEvt.busOff      = next_st.errSt == cei_pkg::BUS_OFF && st.errSt != cei_pkg::BUS_OFF;
    stEvt.passive     = next_st.errSt == cei_pkg::ERR_PASSIVE &&
                        st.errSt != cei_pkg::ERR_PASSIVE;
    stEvt.warnLevel   = warnNext & ~warnNow;
    stEvt.stampOvf    = stampMsb & ~st.stampPrev;

    next_st.sticky0 = st.sticky0 & ~clrLine0;
    next_st.sticky1 = st.sticky1 & ~clrLine1;
    if (globalLineSelect)
      next_st.sticky1 = next_st.sticky1 | stEvt;
    else
      next_st.sticky0 = next_st.sticky0 | stEvt;

    next_st.mbPend = (st.mbPend & ~mailboxClr) | (mailboxEvent & mailboxMask);
    pend0 = next_st.mbPend & ~mailboxLevel;
    pend1 = next_st.mbPend & mailboxLevel;

    next_st.line0.bits.sticky   = next_st.sticky0;
    next_st.line1.bits.sticky   = next_st.sticky1;
    next_st.line0.bits.abortAck = abortAckAny & ~globalLineSelect;
    next_st.line1.bits.abortAck = abortAckAny & globalLineSelect;
    next_st.line0.bits.msgLost  = msgLostAny & ~globalLineSelect;
    next_st.line1.bits.msgLost  = msgLostAny & globalLineSelect;
    next_st.line0.bits.timeout  = |(timeoutStatus & ~mailboxLevel);
    next_st.line1.bits.timeout  = |(timeoutStatus & mailboxLevel);
    next_st.line0.bits.mbEvent  = |pend0;
    next_st.line1.bits.mbEvent  = |pend1;
    next_st.line0.vector = cei_highest(pend0);
    next_st.line1.vector = cei_highest(pend1);

    clrHit0 = (|clrLine0) | (|(mailboxClr & ~mailboxLevel));
    clrHit1 = (|clrLine1) | (|(mailboxClr & mailboxLevel));
    next_st.irq0 = (|(next_st.line0.bits & globalMask)) & ~(clrHit0 & st.irq0);
    next_st.irq1 = (|(next_st.line1.bits & globalMask)) & ~(clrHit1 & st.irq1);
  end

  // State register; every output below is a field of it.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st            <= '0;
      st.grant      <= `CEI_GRANT_RST;
      st.rxSeenHigh <= `CEI_SEEN_RST;
    end
    else
      st <= next_st;
  end

  assign txErrorCount     = st.tec;
  assign rxErrorCount     = st.rec;
  assign configWriteGrant = st.grant;
  assign cfgWriteAccept   = st.cfgAccept;
  assign powerdownAck     = st.pdAck;
  assign rxActive         = st.rxAct;
  assign txActive         = st.txAct;
  assign busOff           = st.offState;
  assign flagRegLine0     = st.line0;
  assign flagRegLine1     = st.line1;
  assign irqLine0         = st.irq0;
  assign irqLine1         = st.irq1;

  // Checks on the registered behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_recover_ready;
    st.errSt == cei_pkg::BUS_OFF && autoBusRecoveryEn && st.rec == `CEI_REC_RECOVER;
  endsequence

  sequence s_bus_on_clean;
    st.tec == 9'h000 && st.rec == 8'h00 && st.errSt == cei_pkg::ERR_ACTIVE;
  endsequence

  a_grant_latency: assert property (initReq && st.rxSeenHigh |=> configWriteGrant)
    else $error("Grant did not set one cycle after access");
  a_write_gate: assert property (cfgWriteAccept |-> $past(cfgWriteReq && st.grant))
    else $error("Config write accepted without grant");
  a_regrant_pin: assert property ($rose(st.grant) |-> $past(st.rxSeenHigh))
    else $error("Grant set again without rx high");
  a_pd_ack: assert property (powerDownReq && !proto.rxBusy && !proto.txBusy
                             |=> powerdownAck)
    else $error("Power-down ack missing");
  a_rx_active: assert property (proto.rxBusy && st.errSt == cei_pkg::ERR_ACTIVE
                                && !proto.txErr |=> rxActive)
    else $error("Rx activity not shown");
  a_busoff_quiet: assert property (busOff |-> !rxActive && !txActive
                                   && txErrorCount >= `CEI_BUSOFF_LIMIT)
    else $error("Traffic shown during bus-off");
  a_rec_hold: assert property (st.errSt != cei_pkg::BUS_OFF && !proto.rxOk
                               && {1'b0, st.rec} >= `CEI_PASSIVE_LIMIT
                               |=> rxErrorCount <= $past(rxErrorCount))
    else $error("Rx counter rose above passive limit");
  a_rec_reload: assert property (st.errSt != cei_pkg::BUS_OFF && proto.rxOk
                                 && !proto.txErr && !leaveInit
                                 && {1'b0, st.rec} >= `CEI_PASSIVE_LIMIT
                                 |=> rxErrorCount == `CEI_REC_RELOAD)
    else $error("Rx counter not reloaded");
  a_auto_recover: assert property (s_recover_ready |=> s_bus_on_clean ##1 !busOff)
    else $error("Automatic bus-on failed");
  a_irq_line: assert property (irqLine0 |-> |(flagRegLine0.bits & $past(globalMask)))
    else $error("Line 0 active without enabled flag");
  a_stamp_ovf: assert property ($rose(st.stampPrev) && !$past(globalLineSelect)
                                |-> flagRegLine0.bits.sticky.stampOvf)
    else $error("Stamp overflow flag not set");

endmodule
`default_nettype wire

// ===== cei_cfg.svh
// Constants for the CAN error counter, status and interrupt flag block.
// Assumes a single 100 MHz core clock; counts are in bus bits or events.
`ifndef CEI_CFG_SVH
`define CEI_CFG_SVH
`define CEI_WARN_LIMIT    9'h060
`define CEI_PASSIVE_LIMIT 9'h080
`define CEI_BUSOFF_LIMIT  9'h100
`define CEI_TX_ERR_STEP   9'h008
`define CEI_RX_ERR_STEP   8'h08
`define CEI_REC_RELOAD    8'h77
`define CEI_REC_RECOVER   8'h80
`define CEI_RUN_LAST      4'ha
`define CEI_GRANT_RST     1'b1
`define CEI_SEEN_RST      1'b1
`endif

// ===== cei_pkg.sv
// Types shared by the CAN error counter, status and interrupt flag block.
// Assumes cei_cfg.svh is included by the design files that need numbers.
package cei_pkg;
  typedef enum logic [1:0] {
    ERR_ACTIVE  = 2'b00,
    ERR_PASSIVE = 2'b01,
    BUS_OFF     = 2'b10
  } cei_err_state_t;

  // Flags that hardware sets and software clears by writing a one.
  typedef struct packed {
    logic writeDenied;
    logic wakeup;
    logic busOff;
    logic passive;
    logic warnLevel;
    logic stampOvf;
  } cei_sticky_t;

  typedef struct packed {
    logic        mbEvent;
    logic        abortAck;
    logic        msgLost;
    logic        timeout;
    cei_sticky_t sticky;
  } cei_fbits_t;

  typedef struct packed {
    cei_fbits_t bits;
    logic [4:0] vector;
  } cei_flags_t;

  // Same-clock status and event pulses from the protocol engine.
  typedef struct packed {
    logic rxBusy;
    logic txBusy;
    logic bitTick;
    logic txErr;
    logic txOk;
    logic rxErr1;
    logic rxErr8;
    logic rxOk;
  } cei_proto_t;
endpackage

// ===== cei_bus_node.sv
// Model of the other CAN nodes: drives bursts of bus bits and a bit tick.
// Assumes one core clock; the tick stands still between bursts.
`timescale 1ns/1ps
`default_nettype none
module cei_bus_node #(
  parameter int BIT_CYCLES = 5
) (
  input  wire logic        core_clk,  // Core clock.
  input  wire logic        rst_n,     // Reset, active low.
  input  wire logic        sendReq,   // Start a burst.
  input  wire logic [11:0] sendCount, // Bits in the burst.
  input  wire logic        sendLevel, // Bit level, 1 is recessive.
  output logic             busRxPin,  // Bus level seen by the block.
  output logic             bitTick,   // One pulse late in each bit.
  output logic             busy       // Burst in progress.
);
  logic [11:0] left;
  int          phase;
  // The tick comes late in each bit so the synchronised level has settled.
  // An undriven bus floats recessive, so the pin returns high after a burst.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left <= '0;
      phase <= 0;
      busRxPin <= 1'b1;
      bitTick <= 1'b0;
      busy <= 1'b0;
    end
    else if (sendReq && !busy)
    begin
      left <= sendCount;
      phase <= 0;
      busy <= 1'b1;
      busRxPin <= sendLevel;
    end
    else if (busy)
    begin
      bitTick <= (phase == BIT_CYCLES - 2);
      phase <= (phase == BIT_CYCLES - 1) ? 0 : phase + 1;
      if (phase == BIT_CYCLES - 1)
      begin
        left <= left - 12'h001;
        busy <= (left != 12'h001);
        busRxPin <= (left == 12'h001) ? 1'b1 : busRxPin;
      end
    end
    else
      bitTick <= 1'b0;
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the status, error counter and flag block.
// Assumes the bus node model supplies the receive pin and the bit tick.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
`define WAITV(s, v, n) for (int w = 0; w < n && (s) !== (v); w++) cyc(1);
module tb;
  logic        core_clk, rst_n, initReq, pdReq, cfgReq, auto_bus_recovery_en, gls, irqS;
  logic        abortAny, lostAny, wdEvt, wuEvt, stampMsb, sendReq, sendLvl;
  logic        grant, accept, pdAck, rxAct, txAct, busOff, irq0, irq1, pin, tick, nBusy;
  logic [11:0] sendCnt;
  logic [31:0] mbMask, mbLvl, mbEvt, mbClr, toStat, pend;
  logic [8:0]  tec;
  logic [7:0]  rec;
  logic [4:0]  ev;
  int          miscompares, checks_done, cycles, mt, mr;
  cei_pkg::cei_fbits_t  gMask;
  cei_pkg::cei_sticky_t clr0, clr1, c;
  cei_pkg::cei_proto_t  proto, pr;
  cei_pkg::cei_flags_t  f0, f1, fl, fo;

  // The tick comes from the bus model, the other engine pulses from the bench.
  assign proto = {pr[7:6], tick, pr[4:0]};
  assign fl = gls ? f1 : f0;
  assign fo = gls ? f0 : f1;
  assign irqS = gls ? irq1 : irq0;

  cei_status_irq dut_u (.core_clk(core_clk), .rst_n(rst_n), .busRxPin(pin),
    .initReq(initReq), .powerDownReq(pdReq), .cfgWriteReq(cfgReq),
    .autoBusRecoveryEn(auto_bus_recovery_en), .globalLineSelect(gls), .globalMask(gMask),
    .mailboxMask(mbMask), .mailboxLevel(mbLvl), .mailboxEvent(mbEvt), .mailboxClr(mbClr),
    .timeoutStatus(toStat), .abortAckAny(abortAny), .msgLostAny(lostAny),
    .writeDeniedEvt(wdEvt), .wakeupEvt(wuEvt), .stampMsb(stampMsb), .clrLine0(clr0),
    .clrLine1(clr1), .proto(proto), .configWriteGrant(grant), .cfgWriteAccept(accept),
    .powerdownAck(pdAck), .rxActive(rxAct), .txActive(txAct), .busOff(busOff),
    .txErrorCount(tec), .rxErrorCount(rec), .flagRegLine0(f0), .flagRegLine1(f1),
    .irqLine0(irq0), .irqLine1(irq1));
  cei_bus_node node_u (.core_clk(core_clk), .rst_n(rst_n), .sendReq(sendReq),
    .sendCount(sendCnt), .sendLevel(sendLvl), .busRxPin(pin), .bitTick(tick), .busy(nBusy));

  // Reference counter steps; e is {txErr, txOk, rxErr1, rxErr8, rxOk}.
  function automatic int nxtTec(int t, logic [4:0] e);
    return e[4] ? ((t + 8 > 256) ? 256 : t + 8) : (e[3] && t > 0) ? t - 1 : t;
  endfunction
  function automatic int nxtRec(int r, logic [4:0] e);
    if (e[0])
      return (r >= 128) ? 119 : (r > 0) ? r - 1 : 0;
    return (r >= 128) ? r : r + (e[2] ? 1 : 0) + (e[1] ? 8 : 0);
  endfunction
  function automatic int hiIdx(logic [31:0] v);
    int k;
    k = 0;
    for (int i = 0; i < 32; i++)
      if (v[i])
        k = i;
    return k;
  endfunction

  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic summarize;
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One engine pulse, then compare both counters with the reference.
  task automatic step(logic [4:0] e);
    pr[4:0] = e;
    cyc(1);
    pr[4:0] = '0;
    mt = nxtTec(mt, e);
    mr = nxtRec(mr, e);
    `CHK("tec", 9'(mt), tec)
    `CHK("rec", 8'(mr), rec)
    cyc(1); // Keeps the pulses of two calls apart.
  endtask
  task automatic send(int n, logic lvl);
    sendCnt = 12'(n);
    sendLvl = lvl;
    sendReq = 1'b1;
    cyc(1);
    sendReq = 1'b0;
    `WAITV(nBusy, 1'b0, n * 5 + 5)
    cyc(4);
  endtask
  // Write-one clear on the selected line only.
  task automatic clrL(cei_pkg::cei_sticky_t v);
    clr0 = gls ? '0 : v;
    clr1 = gls ? v : '0;
    cyc(1);
    clr0 = '0;
    clr1 = '0;
  endtask
  task automatic chkMb;
    `CHK("mb0", |(pend & ~mbLvl), f0.bits.mbEvent)
    `CHK("mb1", |(pend & mbLvl), f1.bits.mbEvent)
    `CHK("vec0", 5'(hiIdx(pend & ~mbLvl)), f0.vector)
    `CHK("vec1", 5'(hiIdx(pend & mbLvl)), f1.vector)
    `CHK("to1", |(toStat & mbLvl), f1.bits.timeout)
    `CHK("to0", |(toStat & ~mbLvl), f0.bits.timeout)
  endtask

  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Cut a hang short; the whole run needs about eight thousand cycles.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      summarize();
    end
  end

  // Main sequence: grant, activity, counters, bus-off, flags, mailboxes.
  initial
  begin
    {rst_n, pdReq, cfgReq, auto_bus_recovery_en, gls, abortAny, lostAny, wdEvt, wuEvt, stampMsb} = '0;
    {sendReq, sendLvl, sendCnt, mbMask, mbLvl, mbEvt, mbClr, toStat, pend} = '0;
    {gMask, clr0, clr1, c, pr} = '0;
    initReq = 1'b1;
    mt = 0;
    mr = 0;
    void'($urandom(32'he1ff));
    cyc(6);
    `CHK("grant rst", 1'b1, grant)
    rst_n = 1'b1;
    cyc(2);
    cfgReq = 1'b1;
    cyc(1);
    cfgReq = 1'b0;
    `CHK("accept", 1'b1, accept)
    initReq = 1'b0;
    cyc(1);
    `CHK("grant off", 1'b0, grant)
    cyc(5);
    initReq = 1'b1;
    cyc(1);
    `CHK("grant on", 1'b1, grant)
    sendCnt = 12'h008;
    sendReq = 1'b1;
    cyc(1);
    sendReq = 1'b0;
    cyc(4);
    initReq = 1'b0;
    cyc(2);
    cfgReq = 1'b1;
    cyc(1);
    cfgReq = 1'b0;
    `CHK("refused", 1'b0, accept)
    initReq = 1'b1;
    cyc(5);
    `CHK("grant held", 1'b0, grant)
    `WAITV(grant, 1'b1, 60)
    `CHK("regrant", 1'b1, grant)
    `CHK("denied flag", 1'b1, f0.bits.sticky.writeDenied)
    repeat (20)
    begin
      pr[7:6] = 2'($urandom);
      cyc(1);
      `CHK("rx act", pr[7], rxAct)
      `CHK("tx act", pr[6], txAct)
    end
    pr[7:6] = '0;
    pdReq = 1'b1;
    `WAITV(pdAck, 1'b1, 20)
    `CHK("pd ack", 1'b1, pdAck)
    pdReq = 1'b0;
    `WAITV(pdAck, 1'b0, 20)
    `CHK("pd ack off", 1'b0, pdAck)
    repeat (300)
    begin
      ev = 5'(5'h01 << $urandom_range(4));
      if (ev[4] && mt > 240)
        ev = 5'h08;
      step(ev);
    end
    initReq = 1'b0;
    cyc(3);
    mt = 0;
    mr = 0;
    `CHK("tec init", 9'h000, tec)
    `CHK("rec init", 8'h00, rec)
    repeat (3) step(5'h02);
    repeat (32)
    begin
      pr[4] = 1'b1;
      cyc(1);
      pr[4] = 1'b0;
      cyc(1);
    end
    cyc(2);
    `CHK("tec off", 9'h100, tec)
    `CHK("bus off", 1'b1, busOff)
    `CHK("rec cleared", 8'h00, rec)
    `CHK("off flag", 1'b1, f0.bits.sticky.busOff)
    `CHK("passive flag", 1'b1, f0.bits.sticky.passive)
    `CHK("warn flag", 1'b1, f0.bits.sticky.warnLevel)
    send(10, 1'b1);
    send(1, 1'b0);
    send(10, 1'b1);
    `CHK("run restart", 8'h00, rec)
    send(1, 1'b1);
    `CHK("run count", 8'h01, rec)
    send(1397, 1'b1);
    `CHK("rec full", 8'h80, rec)
    `CHK("still off", 1'b1, busOff)
    auto_bus_recovery_en = 1'b1;
    cyc(3);
    `CHK("bus on", 1'b0, busOff)
    `CHK("tec on", 9'h000, tec)
    `CHK("rec on", 8'h00, rec)
    for (int g = 0; g < 2; g++)
    begin
      gls = g[0];
      clrL('1);
      cyc(1);
      gls = ~gls;
      clrL('1);
      gls = g[0];
      gMask = '0;
      gMask.sticky.wakeup = 1'b1;
      wdEvt = 1'b1;
      cyc(1);
      wdEvt = 1'b0;
      cyc(2);
      `CHK("wd flag", 1'b1, fl.bits.sticky.writeDenied)
      `CHK("masked irq", 1'b0, irqS)
      wuEvt = 1'b1;
      cyc(1);
      wuEvt = 1'b0;
      `CHK("wu irq", 1'b1, irqS)
      `CHK("wu flag", 1'b1, fl.bits.sticky.wakeup)
      `CHK("wu other", 1'b0, fo.bits.sticky.wakeup)
      gMask.sticky.writeDenied = 1'b1;
      c = '0;
      c.wakeup = 1'b1;
      clrL(c);
      `CHK("irq dip", 1'b0, irqS)
      `CHK("wu clr", 1'b0, fl.bits.sticky.wakeup)
      `WAITV(irqS, 1'b1, 3)
      `CHK("irq again", 1'b1, irqS)
      clrL('1);
      cyc(3);
      `CHK("irq idle", 1'b0, irqS)
      {abortAny, lostAny} = 2'h3;
      cyc(2);
      `CHK("abort", 1'b1, fl.bits.abortAck)
      `CHK("lost", 1'b1, fl.bits.msgLost)
      `CHK("abort other", 1'b0, fo.bits.abortAck)
      {abortAny, lostAny} = 2'h0;
      stampMsb = 1'b1;
      cyc(2);
      `CHK("abort gone", 1'b0, fl.bits.abortAck)
      `CHK("stamp ovf", 1'b1, fl.bits.sticky.stampOvf)
      stampMsb = 1'b0;
    end
    gMask = '0;
    repeat (12)
    begin
      mbLvl = $urandom;
      mbMask = $urandom;
      mbEvt = $urandom & $urandom;
      toStat = $urandom & $urandom & $urandom;
      pend |= mbEvt & mbMask;
      cyc(1);
      mbEvt = '0;
      clrL('1);
      cyc(2);
      chkMb();
      mbClr = 32'h1 << hiIdx(pend);
      pend &= ~mbClr;
      cyc(1);
      mbClr = '0;
      cyc(2);
      chkMb();
    end
    summarize();
  end
endmodule
`default_nettype wire
